//--- inc/homing_consts.vh
`ifndef HOMING_CONSTS_VH
`define HOMING_CONSTS_VH
// ****************************************
// method codes, signed byte values
// ****************************************
`define HM_CODE_7 8'h07
`define HM_CODE_11 8'h0B
`define HM_CODE_8 8'h08
`define HM_CODE_12 8'h0C
`define HM_CODE_23 8'h17
`define HM_CODE_27 8'h1B
`define HM_CODE_35 8'h23
`define HM_CODE_37 8'h25
`define HM_CODE_M1 8'hFF
`define HM_CODE_M33 8'hDF
`define HM_CODE_M4 8'hFC
`define HM_CODE_M36 8'hDC
`define HM_CODE_M5 8'hFB
`define HM_CODE_M2 8'hFE
`define HM_CODE_M34 8'hDE
`define HM_CODE_M6 8'hFA
`define HM_CODE_M38 8'hDA
// ****************************************
// homing parameter values and resets
// ****************************************
`define HM_TYPE_RST 8'h00
`define HM_METH_RST 8'h00
`define HM_METH_NONE 8'h00
`define HM_READBACK_RST 8'h00
// ****************************************
// control word bit positions
// ****************************************
`define HM_CW_START 4
`define HM_CW_HALT 8
`endif

//--- rtl/homing_code_map.v
`include "homing_consts.vh"

// ****************************************
// pure lookup from method code to parameter pair
// ****************************************
module homing_code_map (
    // method code in
    input wire [7:0] methodCode,
    // decoded result
    output reg known,
    output reg typeValid,
    output reg [7:0] typeVal,
    output reg [7:0] methVal,
    output reg needServoOn
);
    // positive codes set the method parameter, negative ones the type parameter
    always @* begin
        known = 1'b1;
        typeValid = 1'b0;
        typeVal = `HM_TYPE_RST;
        methVal = `HM_METH_NONE;
        needServoOn = 1'b0;
        case (methodCode)
            `HM_CODE_7: methVal = 8'h07; // RULE_02
            `HM_CODE_11: methVal = 8'h0B; // RULE_02
            `HM_CODE_8: methVal = 8'h08; // RULE_03
            `HM_CODE_12: methVal = 8'h0C; // RULE_03
            `HM_CODE_23: methVal = 8'h17; // RULE_04
            `HM_CODE_27: methVal = 8'h1B; // RULE_04
            `HM_CODE_35: begin
                methVal = 8'h23; // RULE_05
                needServoOn = 1'b1;
            end
            `HM_CODE_37: begin
                methVal = 8'h25; // RULE_05
                needServoOn = 1'b1;
            end
            `HM_CODE_M1: begin
                typeValid = 1'b1;
                typeVal = 8'h00; // RULE_06
            end
            `HM_CODE_M33: begin
                typeValid = 1'b1;
                typeVal = 8'h10; // RULE_06
            end
            `HM_CODE_M4: begin
                typeValid = 1'b1;
                typeVal = 8'h03; // RULE_07
            end
            `HM_CODE_M36: begin
                typeValid = 1'b1;
                typeVal = 8'h13; // RULE_07
            end
            `HM_CODE_M5: begin
                typeValid = 1'b1;
                typeVal = 8'h04; // RULE_08
            end
            `HM_CODE_M2: begin
                typeValid = 1'b1;
                typeVal = 8'h01; // RULE_09
            end
            `HM_CODE_M34: begin
                typeValid = 1'b1;
                typeVal = 8'h11; // RULE_09
            end
            `HM_CODE_M6: begin
                typeValid = 1'b1;
                typeVal = 8'h05; // RULE_10
            end
            `HM_CODE_M38: begin
                typeValid = 1'b1;
                typeVal = 8'h15; // RULE_10
            end
            default: known = 1'b0; // RULE_01
        endcase
    end
endmodule

//--- rtl/homing_method_decoder.v
// What this block does
// RULE_01: an unlisted method value leaves both homing parameters as they were.
// RULE_02: codes 7 and 11 set the method parameter to 07h or 0Bh, reverse after dog, first index.
// RULE_03: codes 8 and 12 set the method parameter to 08h or 0Ch, first index after dog front.
// RULE_04: codes 23 and 27 set the method parameter to 17h or 1Bh, dog front edge as home.
// RULE_05: codes 35 and 37 set 23h or 25h, data-set homing allowed only under servo-on; code checks it only for a start from idle, not a resume from halt.
// RULE_06: codes -1 and -33 set the type parameter to 00h or 10h, dog rear end then index.
// RULE_07: codes -4 and -36 set the type parameter to 03h or 13h, stopper type.
// RULE_08: code -5 sets the type parameter to 04h, servo-on position becomes home at once.
// RULE_09: codes -2 and -34 set the type parameter to 01h or 11h, count type.
// RULE_10: codes -6 and -38 set the type parameter to 05h or 15h, rear end plus shift.
// RULE_11: the method byte is read as a signed two's complement number.
// RULE_12: the master starts homing with a rising start bit and clears it when done.
// RULE_13: halt bit stops the motor; a fresh start edge with halt clear resumes.
// RULE_14: the master issues the store command to keep a written method.
`include "homing_consts.vh"

module homing_method_decoder (
    // clock and reset
    input wire mclk,
    input wire rst_n,
    // method write from the serial register side
    input wire methodWrite,
    input wire [7:0] methodData,
    // control word and drive state
    input wire [15:0] controlWord,
    input wire servoOn,
    input wire homingModeActive,
    input wire homingDone,
    input wire homingAlarm,
    // store request, for nonvolatile copy
    input wire storeReq,
    // decoded parameters and last accepted method
    output reg [7:0] homingTypeParam,
    output reg [7:0] homingMethodParam,
    output reg [7:0] methodReadback,
    output reg storeParamsPulse,
    // to the motion logic
    output reg homingRun,
    output reg haltDecel,
    output reg setHomeNow,
    output reg dataSetHoming
);
    // ****************************************
    // method decode
    // ****************************************
    wire known;
    wire typeValid;
    wire [7:0] typeVal;
    wire [7:0] methVal;
    wire needServoOn;
    wire signed [7:0] methodSigned;

    // the byte is taken as signed so negative codes pick the type table
    assign methodSigned = methodData; // RULE_11

    homing_code_map u_map (
        .methodCode(methodSigned),
        .known(known),
        .typeValid(typeValid),
        .typeVal(typeVal),
        .methVal(methVal),
        .needServoOn(needServoOn)
    );

    // parameter registers; unknown codes leave both untouched
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            homingTypeParam <= `HM_TYPE_RST;
            homingMethodParam <= `HM_METH_RST;
            methodReadback <= `HM_READBACK_RST;
        end else if (methodWrite && known) begin // RULE_01
            methodReadback <= methodData;
            if (typeValid) begin
                homingTypeParam <= typeVal; // RULE_06
                homingMethodParam <= `HM_METH_NONE;
            end else begin
                homingMethodParam <= methVal; // RULE_02
            end
        end
    end

    // store pulse forwarded one cycle; the copy itself lives elsewhere
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            storeParamsPulse <= 1'b0;
        end else begin
            storeParamsPulse <= storeReq; // RULE_14
        end
    end

    // ****************************************
    // start and halt sequencing
    // ****************************************
    localparam ST_IDLE = 2'h0;
    localparam ST_RUN = 2'h1;
    localparam ST_HALT = 2'h2;
    localparam ST_DONE = 2'h3;

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg startPrev_q;
    wire startBit;
    wire haltBit;
    wire startEdge;
    wire dataSetSel;
    wire dataSetOk;
    wire servoOnPos;

    assign startBit = controlWord[`HM_CW_START];
    assign haltBit = controlWord[`HM_CW_HALT];
    assign startEdge = startBit && !startPrev_q; // RULE_12
    assign dataSetSel = (homingMethodParam == 8'h23) || (homingMethodParam == 8'h25);
    // data-set type refuses to start from idle without servo-on
    assign dataSetOk = !dataSetSel || servoOn; // RULE_05
    assign servoOnPos = (homingMethodParam == `HM_METH_NONE) && (homingTypeParam == 8'h04);

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            startPrev_q <= 1'b0;
        end else begin
            startPrev_q <= startBit;
        end
    end

    // only a fresh edge starts; holding the bit high never retriggers
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (startEdge && !haltBit && homingModeActive && dataSetOk) begin
                    state_d = ST_RUN; // RULE_12
                end
            end
            ST_RUN: begin
                if (homingAlarm || homingDone) begin
                    state_d = ST_DONE;
                end else if (haltBit) begin
                    state_d = ST_HALT; // RULE_13
                end
            end
            ST_HALT: begin
                // resume needs halt clear and a new start edge
                if (homingAlarm) begin
                    state_d = ST_DONE;
                end else if (!haltBit && startEdge) begin
                    state_d = ST_RUN; // RULE_13
                end
            end
            ST_DONE: begin
                // wait for the master to drop the start bit
                if (!startBit) begin
                    state_d = ST_IDLE; // RULE_12
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // registered drive outputs
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            homingRun <= 1'b0;
            haltDecel <= 1'b0;
            setHomeNow <= 1'b0;
            dataSetHoming <= 1'b0;
        end else begin
            homingRun <= (state_d == ST_RUN);
            haltDecel <= haltBit; // RULE_13
            // servo-on position type sets home on servo-on, no homing mode needed
            setHomeNow <= servoOnPos && servoOn && !homingRun; // RULE_08
            dataSetHoming <= (state_d == ST_RUN) && dataSetSel; // RULE_05
        end
    end
endmodule

//--- tb/homing_method_decoder_monitor.sv
module homing_method_decoder_monitor (
    // clock and reset
    input wire mclk,
    input wire rst_n,
    // master side
    input wire methodWrite,
    input wire [7:0] methodData,
    input wire [15:0] controlWord,
    input wire servoOn,
    input wire storeReq,
    // decoded side
    input wire [7:0] homingTypeParam,
    input wire [7:0] homingMethodParam,
    input wire storeParamsPulse,
    input wire homingRun
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // port checks
    // ****************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    function automatic logic listed(input logic [7:0] d);
        return d inside {8'h07, 8'h0B, 8'h08, 8'h0C, 8'h17, 8'h1B, 8'h23, 8'h25, 8'hFF,
            8'hDF, 8'hFC, 8'hDC, 8'hFB, 8'hFE, 8'hDE, 8'hFA, 8'hDA};
    endfunction
    // one taken write of a given code
    sequence s_wr(logic [7:0] c);
        methodWrite && methodData == c;
    endsequence
    a_unlisted_keeps: assert property (methodWrite && !listed(methodData) |=>
        $stable(homingTypeParam) && $stable(homingMethodParam)) else $error("param moved");
    a_code_seven: assert property (s_wr(8'h07) |=> homingMethodParam == 8'h07)
        else $error("code 7 wrong");
    a_stopper_type: assert property (s_wr(8'hFC) |=> homingTypeParam == 8'h03)
        else $error("code -4 wrong");
    a_servo_home: assert property (s_wr(8'hFB) |=> homingTypeParam == 8'h04)
        else $error("code -5 wrong");
    a_sign_split: assert property (methodWrite && listed(methodData) && methodData[7]
        |=> homingMethodParam == 8'h00) else $error("negative code kept method");
    a_data_set_servo: assert property ($rose(homingRun) && homingMethodParam
        inside {8'h23, 8'h25} |-> $past(servoOn)) else $error("data set without servo");
    a_start_edge: assert property ($rose(homingRun) |-> $past(controlWord[4])
        && !$past(controlWord[4], 2) && !$past(controlWord[8])) else $error("bad start");
    a_halt_stops: assert property (homingRun && controlWord[8] |=> !homingRun)
        else $error("halt ignored");
    a_store_follows: assert property (storeReq |=> storeParamsPulse)
        else $error("store lost");
endmodule
bind homing_method_decoder homing_method_decoder_monitor u_homing_method_decoder_monitor (
    .mclk, .rst_n, .methodWrite, .methodData, .controlWord, .servoOn, .storeReq,
    .homingTypeParam, .homingMethodParam, .storeParamsPulse, .homingRun);

//--- tb/bus_master_model.sv
module bus_master_model (
    // clock
    input wire mclk,
    // method writes and control word
    output logic methodWrite,
    output logic [7:0] methodData,
    output logic [15:0] controlWord,
    output logic storeReq
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle at time zero, reserved control bits stay zero
    initial begin
        methodWrite = 1'b0;
        methodData = 8'h00;
        controlWord = 16'h0000;
        storeReq = 1'b0;
    end
    // method write, then the store command so it survives power loss
    task automatic write_method(input logic [7:0] code);
        @(posedge mclk);
        methodWrite <= 1'b1;
        methodData <= code;
        @(posedge mclk);
        methodWrite <= 1'b0;
        methodData <= ~code; // stale data would hide a missing strobe check
        storeReq <= 1'b1;
        @(posedge mclk);
        storeReq <= 1'b0;
        #1;
    endtask
    // one bit per edge keeps start and halt edges apart
    task automatic set_bit(input int pos, input logic val);
        @(posedge mclk);
        controlWord[pos] <= val;
    endtask
endmodule

//--- tb/tb_homing_method_decoder.sv
module tb_homing_method_decoder;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic servoOn = 1'b0;
    logic homingModeActive = 1'b0;
    logic homingDone = 1'b0;
    logic homingAlarm = 1'b0;
    logic methodWrite, storeReq, storeParamsPulse, homingRun, haltDecel, setHomeNow;
    logic dataSetHoming;
    logic [7:0] methodData, homingTypeParam, homingMethodParam, methodReadback;
    logic [15:0] controlWord;
    int miscompares = 0;
    int nCompared = 0;
    logic [15:0] tbl [17] = '{16'h0707, 16'h0B0B, 16'h0808, 16'h0C0C, 16'h1717, 16'h1B1B,
        16'h2323, 16'h2525, 16'hFF00, 16'hDF10, 16'hFC03, 16'hDC13, 16'hFB04, 16'hFE01,
        16'hDE11, 16'hFA05, 16'hDA15};
    // ****************
    // clock, design and master
    // ****************
    always #5 mclk = ~mclk;
    homing_method_decoder u_homing_method_decoder (.mclk, .rst_n, .methodWrite, .methodData,
        .controlWord, .servoOn, .homingModeActive, .homingDone, .homingAlarm, .storeReq,
        .homingTypeParam, .homingMethodParam, .methodReadback, .storeParamsPulse,
        .homingRun, .haltDecel, .setHomeNow, .dataSetHoming);
    bus_master_model u_bus_master_model (.mclk, .methodWrite, .methodData, .controlWord,
        .storeReq);
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        nCompared++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // every listed code; a positive code leaves the type value alone
    task automatic t_codes;
        logic [7:0] eT;
        logic [7:0] eM;
        eT = 8'h00;
        eM = 8'h00;
        foreach (tbl[i]) begin
            u_bus_master_model.write_method(tbl[i][15:8]);
            if (tbl[i][15]) begin
                eT = tbl[i][7:0];
                eM = 8'h00;
            end else begin
                eM = tbl[i][7:0];
            end
            check(homingTypeParam, eT);
            check(homingMethodParam, eM);
        end
    endtask
    task automatic pulse_end(input logic alarm);
        @(posedge mclk);
        homingDone <= ~alarm;
        homingAlarm <= alarm;
        @(posedge mclk);
        homingDone <= 1'b0;
        homingAlarm <= 1'b0;
        tick(1);
        check(8'(homingRun), 8'h00);
        u_bus_master_model.set_bit(4, 1'b0);
    endtask
    // halt in mid-run, then resume only on a fresh start edge
    task automatic t_halt_resume;
        u_bus_master_model.write_method(8'h07);
        u_bus_master_model.set_bit(4, 1'b1);
        tick(2);
        check(8'(homingRun), 8'h01);
        u_bus_master_model.set_bit(8, 1'b1);
        tick(2);
        check(8'(homingRun), 8'h00);
        check(8'(haltDecel), 8'h01);
        u_bus_master_model.set_bit(8, 1'b0);
        tick(2);
        check(8'(homingRun), 8'h00);
        u_bus_master_model.set_bit(4, 1'b0);
        u_bus_master_model.set_bit(4, 1'b1);
        tick(2);
        check(8'(homingRun), 8'h01);
        pulse_end(1'b0);
    endtask
    // data-set homing refused while the servo is off
    task automatic t_data_set;
        u_bus_master_model.write_method(8'h23);
        u_bus_master_model.set_bit(4, 1'b1);
        tick(2);
        check(8'(homingRun), 8'h00);
        u_bus_master_model.set_bit(4, 1'b0);
        @(posedge mclk);
        servoOn <= 1'b1;
        u_bus_master_model.set_bit(4, 1'b1);
        tick(2);
        check(8'(dataSetHoming), 8'h01);
        pulse_end(1'b1);
    endtask
    // servo-on position as home, then unlisted values change nothing
    task automatic t_servo_unlisted;
        logic [7:0] bad [3] = '{8'h09, 8'hF9, 8'h80};
        // homing mode off: servo-on home must still work, a start must not
        @(posedge mclk);
        homingModeActive <= 1'b0;
        u_bus_master_model.write_method(8'hFB);
        check(8'(storeParamsPulse), 8'h01);
        tick(1);
        check(8'(setHomeNow), 8'h01);
        u_bus_master_model.set_bit(4, 1'b1);
        tick(2);
        check(8'(homingRun), 8'h00);
        check(8'(setHomeNow), 8'h01);
        u_bus_master_model.set_bit(4, 1'b0);
        foreach (bad[i]) begin
            u_bus_master_model.write_method(bad[i]);
            check(homingTypeParam, 8'h04);
            check(homingMethodParam, 8'h00);
            check(methodReadback, 8'hFB);
        end
    endtask
    task automatic complete_run;
        $display("compared %0d mismatched %0d", nCompared, miscompares);
        if (miscompares == 0 && nCompared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // main sequence after 20 cycles of reset
    initial begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        homingModeActive <= 1'b1;
        t_codes;
        t_halt_resume;
        t_data_set;
        t_servo_unlisted;
        complete_run;
    end
    // the tests need about 125 cycles; a hang is cut well beyond that
    initial begin
        #20us;
        miscompares++;
        complete_run;
    end
endmodule
